// File: rtl/icm_pkg.sv
package icm_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int PC_W   = 13;
  localparam int INSN_W = 14;
  localparam int DADR_W = 8;
  localparam int DAT_W  = 8;
  localparam int PHASES = 4;

  // ----------------------------------------------------------------------
  // vectors, offsets, reset values
  // ----------------------------------------------------------------------
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  localparam logic [12:0] TOP_512      = 13'h01ff;
  localparam logic [12:0] TOP_1K       = 13'h03ff;
  localparam logic [12:0] TOP_2K       = 13'h07ff;
  localparam logic [12:0] TOP_8K       = 13'h1fff;
  localparam logic [13:0] NOP_WORD     = 14'h0000;
  localparam logic [7:0]  STATUS_OFS   = 8'h03;
  localparam logic [7:0]  FSP_OFS      = 8'h04;
  localparam logic [7:0]  INDIRECT_OFS = 8'h00;
  localparam int          BANK_BIT_POS = 5;
  localparam logic [6:0]  BANK_TOP     = 7'h7f;
  // mirrored low offsets: 00h, 02h, 03h, 04h, 0ah, 0bh
  localparam logic [11:0] MIRROR_MASK  = 12'hc1d;
  localparam logic [3:0]  PB_RST       = 4'h0;
  localparam logic [1:0]  PHASE_RST    = 2'h0;

  // ----------------------------------------------------------------------
  // jump opcode: top three bits 3'b101 (call) or the jump form
  // ----------------------------------------------------------------------
  localparam logic [2:0]  JUMP_OP      = 3'h5;
  localparam logic [1:0]  ALT_OP       = 2'h2;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ICM_PH1 = 4'b0001,
    ICM_PH2 = 4'b0010,
    ICM_PH3 = 4'b0100,
    ICM_PH4 = 4'b1000
  } icm_phase_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } icm_dmem_t;

endpackage

// File: rtl/icm_phase_gen.sv
// ------------------------------------------------------------------------
// four phase generator
// ------------------------------------------------------------------------
module icm_phase_gen (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  output icm_pkg::icm_phase_t   phase,
  output logic                  cycle_rate_output
);

  logic [1:0] cnt_reg;

  // divide the oscillator by four
  // phase divide counter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg <= icm_pkg::PHASE_RST;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  // one-hot decode keeps phases non-overlapping
  always_comb begin
    case (cnt_reg)
      2'h0:    phase = icm_pkg::ICM_PH1;
      2'h1:    phase = icm_pkg::ICM_PH2;
      2'h2:    phase = icm_pkg::ICM_PH3;
      default: phase = icm_pkg::ICM_PH4;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cycle_rate_output <= 1'b0;
    end else begin
      cycle_rate_output <= (cnt_reg == 2'h0) || (cnt_reg == 2'h1);
    end
  end

  chk_phase_onehot: assert property (@(posedge clk_sys)
    disable iff (srst) $onehot(phase)) else $error("phase not one-hot");

  chk_phase_order: assert property (@(posedge clk_sys)
    disable iff (srst) phase == icm_pkg::ICM_PH1 |=> phase == icm_pkg::ICM_PH2
    ##1 phase == icm_pkg::ICM_PH3 ##1 phase == icm_pkg::ICM_PH4)
    else $error("phase order broken");

endmodule

// File: rtl/icm_core_timing.sv
module icm_core_timing (
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic [1:0]         mem_size_sel,
  input  wire logic [13:0]        prog_rdata,
  output logic      [12:0]        prog_addr,
  output icm_pkg::icm_dmem_t      dmem,
  input  wire logic [7:0]         dmem_rdata,
  input  wire logic [7:0]         exec_result,
  input  wire logic               exec_write,
  input  wire logic               irq_req,
  output logic                    irq_taken,
  input  wire logic [3:0]         portb_upper_pins,
  output logic                    portb_change,
  input  wire logic               prog_mode,
  output logic                    prog_clock,
  output logic                    prog_data,
  output logic                    cycle_rate_output,
  output logic      [12:0]        program_counter,
  output logic      [13:0]        instruction_latch,
  output logic                    bank_select_bit,
  output logic      [7:0]         file_select_pointer,
  output logic      [3:0]         phase_out,
  output logic                    flush_out
);

  // ----------------------------------------------------------------------
  // phase generation
  // ----------------------------------------------------------------------
  icm_pkg::icm_phase_t phase;
  logic phase_one, phase_two, phase_three, phase_four;

  icm_phase_gen u_phase (
    .clk_sys           (clk_sys),
    .srst              (srst),
    .phase             (phase),
    .cycle_rate_output (cycle_rate_output)
  );

  assign phase_one   = phase[0];
  assign phase_two   = phase[1];
  assign phase_three = phase[2];
  assign phase_four  = phase[3];
  assign phase_out   = phase;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // wrap an address onto the implemented size
  function automatic logic [12:0] wrap_addr(input logic [12:0] a,
                                            input logic [1:0] sel);
    logic [12:0] top;
    case (sel)
      2'h0:    top = icm_pkg::TOP_512;
      2'h1:    top = icm_pkg::TOP_1K;
      2'h2:    top = icm_pkg::TOP_2K;
      default: top = icm_pkg::TOP_8K;
    endcase
    return a & top;
  endfunction

  // jump-class decode, also used by the checker
  function automatic logic is_jump(input logic [13:0] w);
    return (w[13:11] == icm_pkg::JUMP_OP) || (w[13:12] == icm_pkg::ALT_OP);
  endfunction

  // low offsets shared by both banks
  function automatic logic is_mirror(input logic [6:0] ofs);
    return (ofs < 7'h0c) && icm_pkg::MIRROR_MASK[ofs[3:0]];
  endfunction

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pb_meta_reg, pb_sync_reg, pb_last_reg;
  logic       irq_meta_reg, irq_sync_reg;

  // two flops before logic sees a port B or interrupt pin; prog_mode is used unsynchronised
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pb_meta_reg  <= icm_pkg::PB_RST;
      pb_sync_reg  <= icm_pkg::PB_RST;
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end else begin
      pb_meta_reg  <= portb_upper_pins;
      pb_sync_reg  <= pb_meta_reg;
      irq_meta_reg <= irq_req;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pb_last_reg  <= icm_pkg::PB_RST;
      portb_change <= 1'b0;
    end else begin
      pb_last_reg  <= pb_sync_reg;
      portb_change <= |(pb_sync_reg ^ pb_last_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prog_clock <= 1'b0;
      prog_data  <= 1'b0;
    end else begin
      prog_clock <= prog_mode & pb_sync_reg[2];
      prog_data  <= prog_mode & pb_sync_reg[3];
    end
  end

  // ----------------------------------------------------------------------
  // program counter and fetch
  // ----------------------------------------------------------------------
  logic [12:0] pc_reg, pc_next;
  logic [12:0] fetch_addr_reg;
  logic [13:0] fetch_reg;
  logic [13:0] ir_reg;
  logic        flush_reg;
  logic        jump_now;
  logic        irq_pend_reg;

  // a taken jump in execute is known by phase four
  // jump costs one extra cycle
  assign jump_now = phase_four && !flush_reg && is_jump(ir_reg);

  always_comb begin
    pc_next = pc_reg;
    if (phase_one) begin
      pc_next = wrap_addr(pc_reg + 13'h0001, mem_size_sel);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_reg <= icm_pkg::RESET_VECTOR;
    end else if (phase_four && irq_pend_reg) begin
      pc_reg <= icm_pkg::IRQ_VECTOR;
    end else if (jump_now) begin
      pc_reg <= wrap_addr({2'h0, ir_reg[10:0]}, mem_size_sel);
    end else begin
      pc_reg <= pc_next;
    end
  end

  // interrupt request held until the cycle boundary
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_pend_reg <= 1'b0;
      irq_taken    <= 1'b0;
    end else begin
      irq_taken <= phase_four && irq_pend_reg;
      if (irq_sync_reg && !(phase_four && irq_pend_reg)) begin
        irq_pend_reg <= 1'b1;
      end else if (phase_four) begin
        irq_pend_reg <= 1'b0;
      end
    end
  end

  // fetched word latched at phase four
  // fetch address is the counter before its step, so vectors run
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fetch_reg      <= icm_pkg::NOP_WORD;
      fetch_addr_reg <= icm_pkg::RESET_VECTOR;
    end else if (phase_four) begin
      fetch_reg <= prog_rdata;
    end else if (phase_one) begin
      fetch_addr_reg <= pc_reg;
    end
  end

  // overlap: fetched word moves to execute at phase one
  // squash the word behind a jump
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ir_reg    <= icm_pkg::NOP_WORD;
      flush_reg <= 1'b1;
    end else if (phase_four) begin
      flush_reg <= jump_now || irq_pend_reg;
    end else if (phase_one) begin
      ir_reg <= flush_reg ? icm_pkg::NOP_WORD : fetch_reg;
    end
  end

  // counter drives the 13-bit fetch address
  assign prog_addr         = fetch_addr_reg;
  assign program_counter   = pc_reg;
  assign instruction_latch = ir_reg;
  assign flush_out         = flush_reg;

  // ----------------------------------------------------------------------
  // data memory access
  // ----------------------------------------------------------------------
  logic       bank_reg;
  logic [7:0] fsp_reg;
  logic [7:0] operand_reg;
  logic [7:0] eff_addr;
  logic [6:0] dir_ofs;

  // read address is set up from the word that enters execute
  assign dir_ofs = phase_one ? fetch_reg[6:0] : ir_reg[6:0];

  // bank bit forms address bit seven
  // mirrored offsets fold to bank zero
  always_comb begin
    if ({1'b0, dir_ofs} == icm_pkg::INDIRECT_OFS) begin
      eff_addr = fsp_reg;
    end else if (is_mirror(dir_ofs)) begin
      eff_addr = {1'b0, dir_ofs & icm_pkg::BANK_TOP};
    end else begin
      eff_addr = {bank_reg, dir_ofs & icm_pkg::BANK_TOP};
    end
  end

  // operand read phase two, write phase four
  // execution fills phases two to four
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dmem <= '0;
    end else begin
      dmem.rd    <= phase_one && !flush_reg;
      dmem.wr    <= phase_three && !flush_reg && exec_write;
      dmem.addr  <= eff_addr;
      dmem.wdata <= exec_result;
    end
  end

  // operand captured at the end of phase two
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      operand_reg <= 8'h00;
    end else if (dmem.rd) begin
      operand_reg <= dmem_rdata;
    end
  end

  // status bank bit and pointer mirror written data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bank_reg <= 1'b0;
      fsp_reg  <= 8'h00;
    end else if (dmem.wr) begin
      if (dmem.addr[6:0] == icm_pkg::STATUS_OFS[6:0]) begin
        bank_reg <= dmem.wdata[icm_pkg::BANK_BIT_POS];
      end
      if (dmem.addr[6:0] == icm_pkg::FSP_OFS[6:0]) begin
        fsp_reg <= dmem.wdata;
      end
    end
  end

  assign bank_select_bit     = bank_reg;
  assign file_select_pointer = fsp_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // one step at phase one
  chk_pc_advance: assert property (@(posedge clk_sys)
    disable iff (srst) phase_one |=> pc_reg == wrap_addr($past(pc_reg)
    + 13'h0001, mem_size_sel)) else $error("counter did not advance");
  chk_pc_steady: assert property (@(posedge clk_sys)
    disable iff (srst) phase_two |=> $stable(pc_reg))
    else $error("counter moved");
  chk_fetch_latch: assert property (@(posedge clk_sys)
    disable iff (srst) phase_four |=> fetch_reg == $past(prog_rdata))
    else $error("fetch not latched");
  chk_read_phase: assert property (@(posedge clk_sys)
    disable iff (srst) dmem.rd |-> phase_two)
    else $error("read outside phase two");
  chk_write_phase: assert property (@(posedge clk_sys)
    disable iff (srst) dmem.wr |-> phase_four)
    else $error("write outside phase four");
  chk_operand_take: assert property (@(posedge clk_sys)
    disable iff (srst) dmem.rd |=> operand_reg == $past(dmem_rdata))
    else $error("operand not captured");
  chk_jump_flush: assert property (@(posedge clk_sys)
    disable iff (srst) jump_now |=> flush_reg ##1 ir_reg == icm_pkg::NOP_WORD)
    else $error("jump did not flush");
  chk_irq_vector: assert property (@(posedge clk_sys)
    disable iff (srst) phase_four && irq_pend_reg |=>
    pc_reg == icm_pkg::IRQ_VECTOR) else $error("interrupt vector missed");
  chk_reset_vec: assert property (@(posedge clk_sys)
    srst |=> pc_reg == icm_pkg::RESET_VECTOR)
    else $error("reset vector missed");
  chk_pc_wrap: assert property (@(posedge clk_sys)
    disable iff (srst) mem_size_sel == 2'h0 && $stable(mem_size_sel) |->
    pc_reg <= 13'h01ff) else $error("counter beyond memory");
  chk_mirror_map: assert property (@(posedge clk_sys)
    disable iff (srst) dir_ofs == 7'h03 |-> eff_addr == 8'h03)
    else $error("mirror not folded");

endmodule

// File: bench/icm_mem_model.sv
// ------------------------------------------------------------------------
// program store and register file seen by the core
// ------------------------------------------------------------------------
module icm_mem_model (
  input  wire logic               clk_sys,
  input  wire logic [12:0]        prog_addr,
  output logic      [13:0]        prog_rdata,
  input  wire icm_pkg::icm_dmem_t dmem,
  output logic      [7:0]         dmem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [13:0] rom [0:8191];
  logic [7:0]  regs [0:255];
  logic [7:0]  last_q;

  // full 8k store of 14 bit words
  // each word holds its own address, so a wrong fetch shows at once
  initial begin
    for (int i = 0; i < 8192; i++) begin
      rom[i] = {1'b0, 13'(i)};
    end
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'h00;
    end
    last_q = 8'h5a;
  end

  // combinational program read, as the core expects
  assign prog_rdata = rom[prog_addr];

  // two banks of 128 bytes behind one byte address
  always @(posedge clk_sys) begin
    if (dmem.wr) begin
      regs[dmem.addr] <= dmem.wdata;
    end
    if (dmem.rd) begin
      last_q <= regs[dmem.addr];
    end
  end

  // outside a read the bus shows a flipped value, never stale data
  assign dmem_rdata = dmem.rd ? regs[dmem.addr] : ~last_q;
endmodule

// File: bench/instr_cycle_and_memory_map_bench.sv
module instr_cycle_and_memory_map_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic               clk_sys;
  logic               srst;
  logic [1:0]         mem_size_sel;
  logic [13:0]        prog_rdata;
  logic [12:0]        prog_addr;
  icm_pkg::icm_dmem_t dmem;
  logic [7:0]         dmem_rdata;
  logic [7:0]         exec_result;
  logic               exec_write;
  logic               irq_req;
  logic               irq_taken;
  logic [3:0]         portb_upper_pins;
  logic               portb_change;
  logic               prog_mode;
  logic               prog_clock;
  logic               prog_data;
  logic               cycle_rate_output;
  logic [12:0]        program_counter;
  logic [13:0]        instruction_latch;
  logic               bank_select_bit;
  logic [7:0]         file_select_pointer;
  logic [3:0]         phase_out;
  logic               flush_out;
  int                 err_count;
  int                 cmp_count;

  icm_core_timing i_dut (
    .clk_sys, .srst, .mem_size_sel, .prog_rdata, .prog_addr, .dmem,
    .dmem_rdata, .exec_result, .exec_write, .irq_req, .irq_taken,
    .portb_upper_pins, .portb_change, .prog_mode, .prog_clock,
    .prog_data, .cycle_rate_output, .program_counter,
    .instruction_latch, .bank_select_bit, .file_select_pointer,
    .phase_out, .flush_out
  );

  icm_mem_model i_mem (
    .clk_sys, .prog_addr, .prog_rdata, .dmem, .dmem_rdata
  );

  // ----------------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------------
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  // inputs move a fixed 5 ns after the edge, outputs are settled then
  task automatic tick();
    @(posedge clk_sys);
    #5;
  endtask

  task automatic cmp(input string nm, input logic [13:0] exp,
                     input logic [13:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_ph(input logic [3:0] p);
    for (int n = 0; n < 8; n++) begin
      tick();
      if (phase_out === p) return;
    end
    err_count++;
    $display("wrong value phase expected %h seen %h", p, phase_out);
    complete_run();
  endtask

  task automatic wait_hi(input bit sel_irq, input int lim);
    for (int n = 0; n < lim; n++) begin
      tick();
      if ((sel_irq ? irq_taken : portb_change) === 1'b1) return;
    end
    err_count++;
    $display("wrong value pulse expected 1 seen 0");
    complete_run();
  endtask

  // plant a word at the next fetch, then watch its execute cycle
  task automatic issue(input logic [13:0] w, input logic we,
                       input logic [7:0] res, input logic [7:0] adr,
                       input bit chk);
    logic [12:0] a;
    logic [13:0] old;
    wait_ph(4'h8);
    a = prog_addr;
    old = i_mem.rom[a];
    i_mem.rom[a] = w;
    exec_write = we;
    exec_result = res;
    wait_ph(4'h2);
    i_mem.rom[a] = old;
    if (chk) begin
      cmp("read strobe", 14'h1, 14'(dmem.rd));
      cmp("read addr", 14'(adr), 14'(dmem.addr));
    end
    wait_ph(4'h8);
    if (chk) begin
      cmp("read pulse end", 14'h0, 14'(dmem.rd));
      cmp("write strobe", 14'(we), 14'(dmem.wr));
      if (we) cmp("write data", 14'(res), 14'(dmem.wdata));
    end
    exec_write = 1'b0;
  endtask

  // the idle cycle after a jump reads nothing and fetches the target
  task automatic jump_to(input logic [10:0] tgt);
    issue({3'b101, tgt}, 1'b0, 8'h00, 8'h00, 1'b0);
    wait_ph(4'h2);
    cmp("squashed read", 14'h0, 14'(dmem.rd));
    cmp("flush flag", 14'h1, 14'(flush_out));
    wait_ph(4'h8);
    cmp("target fetch", 14'(tgt), 14'(prog_addr));
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    cmp("reset pc", 14'(icm_pkg::RESET_VECTOR), 14'(program_counter));
    cmp("reset latch", 14'h0, instruction_latch);
    cmp("reset flush", 14'h1, 14'(flush_out));
    srst = 1'b0;
    wait_ph(4'h8);
    cmp("reset fetch", 14'(icm_pkg::RESET_VECTOR), 14'(prog_addr));
  endtask

  // phase order, quarter rate output and one pc step per cycle
  task automatic t_phases();
    logic [12:0] p0;
    wait_ph(4'h1);
    for (int i = 0; i < 8; i++) begin
      cmp("phase", 14'(4'h1 << (i % 4)), 14'(phase_out));
      cmp("rate out", 14'(i % 4 == 1 || i % 4 == 2),
          14'(cycle_rate_output));
      if (i == 1) p0 = program_counter;
      if (i > 1 && i < 5) begin
        cmp("pc hold", 14'(p0), 14'(program_counter));
      end
      if (i == 5) begin
        cmp("pc step", 14'(p0 + 13'h1), 14'(program_counter));
      end
      tick();
    end
  endtask

  task automatic t_fetch();
    logic [12:0] a;
    wait_ph(4'h8);
    a = prog_addr;
    wait_ph(4'h2);
    cmp("latched word", {1'b0, a}, instruction_latch);
  endtask

  // bank bit, pointer, mirror and indirect access through the core
  task automatic t_data();
    issue(14'h0083, 1'b1, 8'h20, 8'h03, 1'b1);
    wait_ph(4'h2);
    cmp("bank bit set", 14'h1, 14'(bank_select_bit));
    issue(14'h0020, 1'b0, 8'h00, 8'ha0, 1'b1);
    issue(14'h0084, 1'b1, 8'ha5, 8'h04, 1'b1);
    wait_ph(4'h2);
    cmp("mirrored ptr", 14'h00a5, 14'(file_select_pointer));
    issue(14'h0080, 1'b0, 8'h00, 8'ha5, 1'b1);
    issue(14'h0083, 1'b1, 8'h00, 8'h00, 1'b0);
    wait_ph(4'h2);
    cmp("bank bit clr", 14'h0, 14'(bank_select_bit));
    issue(14'h007f, 1'b1, 8'h3c, 8'h7f, 1'b1);
  endtask

  task automatic t_jump();
    jump_to(11'h100);
    wait_ph(4'h2);
    cmp("target word", 14'h0100, instruction_latch);
  endtask

  // top of each size; the 8k size must run on past 07ffh
  task automatic t_wrap();
    logic [12:0] nxt [4] = '{13'h0000, 13'h0000, 13'h0000, 13'h0800};
    logic [10:0] top [4] = '{11'h1ff, 11'h3ff, 11'h7ff, 11'h7ff};
    for (int s = 0; s < 4; s++) begin
      mem_size_sel = 2'(s);
      jump_to(top[s]);
      wait_ph(4'h8);
      cmp("next fetch", 14'(nxt[s]), 14'(prog_addr));
    end
  endtask

  task automatic t_irq();
    irq_req = 1'b1;
    wait_hi(1'b1, 40);
    irq_req = 1'b0;
    cmp("irq vector", 14'(icm_pkg::IRQ_VECTOR), 14'(program_counter));
    tick();
    cmp("irq pulse", 14'h0, 14'(irq_taken));
  endtask

  task automatic t_portb();
    for (int k = 0; k < 4; k++) begin
      portb_upper_pins = portb_upper_pins ^ 4'(1 << k);
      wait_hi(1'b0, 8);
      tick();
      cmp("change pulse", 14'h0, 14'(portb_change));
    end
  endtask

  // pin six carries the clock, pin seven the data, only in the mode
  task automatic t_prog();
    logic [3:0] pins [3] = '{4'h4, 4'h8, 4'hc};
    logic       mode [3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      prog_mode = mode[i];
      portb_upper_pins = pins[i];
      repeat (6) tick();
      cmp("prog clock", 14'(mode[i] & pins[i][2]), 14'(prog_clock));
      cmp("prog data", 14'(mode[i] & pins[i][3]), 14'(prog_data));
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    err_count = 0;
    cmp_count = 0;
    srst = 1'b1;
    mem_size_sel = 2'h3;
    exec_result = 8'h00;
    exec_write = 1'b0;
    irq_req = 1'b0;
    portb_upper_pins = 4'h0;
    prog_mode = 1'b0;
    repeat (12) tick();
    t_reset();
    t_phases();
    t_fetch();
    t_data();
    t_jump();
    t_wrap();
    t_irq();
    // a second reset in mid-run must bring the vector back
    srst = 1'b1;
    repeat (2) tick();
    t_reset();
    t_portb();
    t_prog();
    complete_run();
  end
endmodule
